/* File: design/lcu_dev_port.sv */
`timescale 1ns/1ps
module lcu_dev_port (
  input wire logic i_clock,
  input wire logic i_rst,
  lcu_dev_if.port bus,
  output logic o_strobe,
  output logic o_write,
  output logic [2:0] o_addr,
  output logic [7:0] o_wdata,
  input wire logic i_ack,
  input wire logic [7:0] i_rdata
);
  typedef enum logic [1:0] {P_IDLE, P_HIGH, P_LOW} lcu_port_t;
  lcu_port_t state_q;
  logic ack_meta_q, ack_s2_q, ack_s3_q, ack_q;
  logic done_q;
  logic [7:0] rdata_q;

  // The acknowledge comes from another chip, so it is resynchronised; a change only counts
  // once the second and third stages agree.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      ack_meta_q <= 1'b0;
      ack_s2_q <= 1'b0;
      ack_s3_q <= 1'b0;
      ack_q <= 1'b0;
    end else begin
      ack_meta_q <= i_ack;
      ack_s2_q <= ack_meta_q;
      ack_s3_q <= ack_s2_q;
      if (ack_s2_q == ack_s3_q) begin
        ack_q <= ack_s3_q;
      end
    end
  end

  // Four-phase handshake; read data is stable while the acknowledge is high, so it is taken
  // without its own synchroniser.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      state_q <= P_IDLE;
      o_strobe <= 1'b0;
      o_write <= 1'b0;
      o_addr <= 3'h0;
      o_wdata <= 8'h00;
      done_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      done_q <= 1'b0;
      unique case (state_q)
        P_IDLE: begin
          if (bus.req) begin
            o_strobe <= 1'b1;
            o_write <= bus.we;
            o_addr <= bus.addr;
            o_wdata <= bus.wdata;
            state_q <= P_HIGH;
          end
        end
        P_HIGH: begin
          if (ack_q) begin
            rdata_q <= i_rdata;
            o_strobe <= 1'b0;
            state_q <= P_LOW;
          end
        end
        P_LOW: begin
          if (!ack_q) begin
            done_q <= 1'b1;
            state_q <= P_IDLE;
          end
        end
      endcase
    end
  end
  assign bus.done = done_q;
  assign bus.rdata = rdata_q;

  strobe_hold_a: assert property (@(posedge i_clock) disable iff (i_rst)
    o_strobe && !ack_q |=> o_strobe && $stable(o_addr) && $stable(o_wdata))
    else $error("Device strobe dropped before acknowledge.");
endmodule

/* File: design/lcu_host.sv */
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/1ps
// Functional notes
// - Direct pin access only while the transmit shift register is empty.
// - Write the direct bit before enabling serial output; it keeps old value.
// - Frame type bit 1 marks an address, 0 marks data.
// - After reset transfers are disabled; set transmit and receive enables first.
// - Change communication mode only while the block is stopped; CMD_PIN_OUT rewrites the mode field without stopping.
// - Soft clear is a separate write after the mode register update; CMD_RECOVER sets it in the same write as the mode field.
// - LIN slave baud rate is set before the first break arrives.
// - Control register writes are whole-byte, type bit set in last write before sending.
// - Soft clear only while the transmit enable bit is 0.
// - A false break is recovered by a soft clear.
module lcu_host
  import lcu_pkg::*;
(
  input wire logic I_CLOCK,
  input wire logic I_RST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [11:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  output logic O_DEV_STROBE,
  output logic O_DEV_WRITE,
  output logic [2:0] O_DEV_ADDR,
  output logic [7:0] O_DEV_WDATA,
  input wire logic I_DEV_ACK,
  input wire logic [7:0] I_DEV_RDATA
);
  import lcu_pkg::*;

  typedef enum logic [1:0] {S_IDLE, S_ISSUE, S_WAIT} lcu_state_t;
  lcu_dev_if dev();
  lcu_state_t state_q;
  lcu_cmd_t cmd_q;
  lcu_step_t step;
  logic [2:0] idx_q;
  logic [CFG_W-1:0] cfg_q;
  logic [7:0] tx_q, rd_q;
  logic done_q, refused_q, break_q;
  logic req_q, we_q;
  logic [2:0] addr_q;
  logic [7:0] wdata_q;
  logic apb_wr, apb_rd, apb_hit, start, set_done, set_refused;

  // Control register byte; mode 3 pins the frame to 8 bits, no parity, one stop.
  function automatic logic [7:0] scr_byte(logic [CFG_W-1:0] c, logic en, logic ad);
    logic [7:0] b;
    logic lin;
    b = 8'h00;
    lin = (c[CFG_MODE_LO+:2] == MODE_LIN);
    b[SCR_PEN] = c[CFG_PEN] && !lin && (c[CFG_MODE_LO+:2] != MODE_MULTI);
    b[SCR_PAR] = c[CFG_PAR];
    b[SCR_SBL] = c[CFG_SBL] && !lin;
    b[SCR_CL] = c[CFG_CL] || lin;
    b[SCR_AD] = ad;
    b[SCR_RXE] = en;
    b[SCR_TXE] = en;
    return b;
  endfunction

  // Mode register byte with the optional soft clear and output enable.
  function automatic logic [7:0] smr_byte(logic [CFG_W-1:0] c, logic clr, logic serial_output_enable);
    logic [7:0] b;
    b = 8'h00;
    b[SMR_MODE_LO+:2] = c[CFG_MODE_LO+:2];
    b[SMR_SOFT_CLEAR] = clr;
    b[SMR_SOE] = serial_output_enable;
    return b;
  endfunction

  // Status register byte; bit order is forced to LSB first in LIN mode.
  function automatic logic [7:0] ssr_byte(logic [CFG_W-1:0] c, logic tx_irq_enable);
    logic [7:0] b;
    b = 8'h00;
    b[SSR_BDS] = c[CFG_BDS] && (c[CFG_MODE_LO+:2] != MODE_LIN);
    b[SSR_TIE] = tx_irq_enable;
    return b;
  endfunction

  // Extended status byte; writing 1 to the break flag leaves it alone.
  function automatic logic [7:0] extended_status_control_byte(logic [CFG_W-1:0] c, logic pin_write_enable, logic break_detect_flag);
    logic [7:0] b;
    b = 8'h00;
    b[EXTENDED_STATUS_CONTROL_BREAK_IRQ_ENABLE] = c[CFG_BREAK_IRQ_ENABLE];
    b[EXTENDED_STATUS_CONTROL_LBD] = break_detect_flag;
    b[EXTENDED_STATUS_CONTROL_LBL_LO+:2] = c[CFG_LBL_LO+:2];
    b[EXTENDED_STATUS_CONTROL_PIN_WRITE_ENABLE] = pin_write_enable;
    b[EXTENDED_STATUS_CONTROL_PIN_DIRECT_BIT] = c[CFG_PIN_LEVEL];
    return b;
  endfunction

  // Each command is a short list of device accesses, indexed by step.
  function automatic lcu_step_t step_of(lcu_cmd_t c, logic [2:0] i, logic [CFG_W-1:0] g,
                                        logic [7:0] tx);
    lcu_step_t s;
    s = '{STEP_END, DEV_SERIAL_MODE, 8'h00};
    unique case (c)
      CMD_CONFIG: begin
        // Stop first so the mode changes on an idle block, then clear in its own write.
        unique case (i)
          3'h0: s = '{STEP_WR, DEV_SERIAL_CONTROL, scr_byte(g, 1'b0, 1'b0)};
          3'h1: s = '{STEP_WR, DEV_SERIAL_MODE, smr_byte(g, 1'b0, g[CFG_SOE])};
          3'h2: s = '{STEP_WR, DEV_SERIAL_MODE, smr_byte(g, 1'b1, g[CFG_SOE])};
          3'h3: s = '{STEP_WR, DEV_SERIAL_STATUS, ssr_byte(g, 1'b0)};
          3'h4: s = '{STEP_WR, DEV_EXT_STATUS_CTRL, extended_status_control_byte(g, 1'b0, 1'b1)};
          3'h5: s = '{STEP_WR, DEV_SERIAL_CONTROL, scr_byte(g, 1'b1, 1'b0)};
          default: s = '{STEP_END, DEV_SERIAL_MODE, 8'h00};
        endcase
      end
      CMD_SEND: begin
        unique case (i)
          3'h0: s = '{STEP_WR, DEV_SERIAL_CONTROL, scr_byte(g, 1'b1, g[CFG_AD])};
          3'h1: s = '{STEP_WR, DEV_TX_DATA, tx};
          3'h2: s = '{STEP_WR, DEV_SERIAL_STATUS, ssr_byte(g, 1'b1)};
          default: s = '{STEP_END, DEV_SERIAL_MODE, 8'h00};
        endcase
      end
      CMD_BREAK: begin
        if (i == 3'h0) begin
          s = '{STEP_WR, DEV_EXT_COMM_CTRL, 8'h01 << EXTENDED_COMM_CONTROL_LBR};
        end
      end
      CMD_PIN_OUT: begin
        // The shift register must be empty, and the level is set before output is enabled.
        unique case (i)
          3'h0: s = '{STEP_RD_CHK, DEV_SERIAL_STATUS, 8'h00};
          3'h1: s = '{STEP_WR, DEV_EXT_STATUS_CTRL, extended_status_control_byte(g, 1'b1, 1'b1)};
          3'h2: s = '{STEP_WR, DEV_SERIAL_MODE, smr_byte(g, 1'b0, 1'b1)};
          default: s = '{STEP_END, DEV_SERIAL_MODE, 8'h00};
        endcase
      end
      CMD_READ_EXT: begin
        if (i == 3'h0) begin
          s = '{STEP_RD, DEV_EXT_STATUS_CTRL, 8'h00};
        end
      end
      CMD_BRK_CLR: begin
        if (i == 3'h0) begin
          s = '{STEP_WR, DEV_EXT_STATUS_CTRL, extended_status_control_byte(g, 1'b0, 1'b0)};
        end
      end
      CMD_RECOVER: begin
        unique case (i)
          3'h0: s = '{STEP_WR, DEV_SERIAL_CONTROL, scr_byte(g, 1'b0, 1'b0)};
          3'h1: s = '{STEP_WR, DEV_SERIAL_MODE, smr_byte(g, 1'b1, g[CFG_SOE])};
          3'h2: s = '{STEP_WR, DEV_SERIAL_CONTROL, scr_byte(g, 1'b1, 1'b0)};
          default: s = '{STEP_END, DEV_SERIAL_MODE, 8'h00};
        endcase
      end
      CMD_STOP: begin
        if (i == 3'h0) begin
          s = '{STEP_WR, DEV_SERIAL_CONTROL, scr_byte(g, 1'b0, 1'b0)};
        end
      end
      default: s = '{STEP_END, DEV_SERIAL_MODE, 8'h00};
    endcase
    return s;
  endfunction

  // APB decode; every access gets exactly one wait-free access phase.
  assign apb_wr = I_PSEL && I_PENABLE && O_PREADY && I_PWRITE;
  assign apb_rd = I_PSEL && !I_PENABLE && !I_PWRITE;
  assign apb_hit = (I_PADDR == APB_CMD) || (I_PADDR == APB_CFG) ||
                   (I_PADDR == APB_TXDATA) || (I_PADDR == APB_STATUS);
  assign start = apb_wr && (I_PADDR == APB_CMD) && (I_PWDATA[3:0] != CMD_NONE);
  assign step = step_of(cmd_q, idx_q, cfg_q, tx_q);

  // Answer one cycle after setup; unmapped addresses answer with an error.
  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      O_PREADY <= 1'b0;
      O_PSLVERR <= 1'b0;
      O_PRDATA <= 32'h0000_0000;
    end else begin
      O_PREADY <= I_PSEL && !I_PENABLE;
      O_PSLVERR <= I_PSEL && !I_PENABLE && !apb_hit;
      if (apb_rd) begin
        unique case (I_PADDR)
          APB_CMD: O_PRDATA <= {28'h0000000, cmd_q};
          APB_CFG: O_PRDATA <= {19'h00000, cfg_q};
          APB_TXDATA: O_PRDATA <= {24'h000000, tx_q};
          APB_STATUS: O_PRDATA <= {16'h0000, rd_q, 4'h0, break_q, refused_q, done_q,
                                   state_q != S_IDLE};
          default: O_PRDATA <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Software-owned settings, held at their power-up values until written.
  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      cfg_q <= '0;
      tx_q <= 8'h00;
    end else if (apb_wr && (I_PADDR == APB_CFG)) begin
      cfg_q <= I_PWDATA[CFG_W-1:0];
    end else if (apb_wr && (I_PADDR == APB_TXDATA)) begin
      tx_q <= I_PWDATA[7:0];
    end
  end

  // Command sequencer: one device access per step, each awaited to completion.
  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      state_q <= S_IDLE;
      cmd_q <= CMD_NONE;
      idx_q <= 3'h0;
      req_q <= 1'b0;
      we_q <= 1'b0;
      addr_q <= 3'h0;
      wdata_q <= 8'h00;
      rd_q <= 8'h00;
    end else begin
      req_q <= 1'b0;
      unique case (state_q)
        S_IDLE: begin
          if (start && !(I_PWDATA[3:0] == CMD_BREAK && cfg_q[CFG_MODE_LO+:2] != MODE_LIN)) begin
            cmd_q <= lcu_cmd_t'(I_PWDATA[3:0]);
            idx_q <= 3'h0;
            state_q <= S_ISSUE;
          end
        end
        S_ISSUE: begin
          if (step.kind == STEP_END) begin
            state_q <= S_IDLE;
          end else begin
            req_q <= 1'b1;
            we_q <= (step.kind == STEP_WR);
            addr_q <= step.addr;
            wdata_q <= step.data;
            state_q <= S_WAIT;
          end
        end
        S_WAIT: begin
          if (dev.done) begin
            if (!we_q) begin
              rd_q <= dev.rdata;
            end
            idx_q <= idx_q + 3'h1;
            if (step.kind == STEP_RD_CHK && !dev.rdata[SSR_TX_BUFFER_EMPTY]) begin
              state_q <= S_IDLE;
            end else begin
              state_q <= S_ISSUE;
            end
          end
        end
      endcase
    end
  end
  assign dev.req = req_q;
  assign dev.we = we_q;
  assign dev.addr = addr_q;
  assign dev.wdata = wdata_q;

  assign set_done = (state_q == S_ISSUE) && (step.kind == STEP_END);
  assign set_refused = (start && ((state_q != S_IDLE) ||
                        (I_PWDATA[3:0] == CMD_BREAK && cfg_q[CFG_MODE_LO+:2] != MODE_LIN))) ||
                       ((state_q == S_WAIT) && dev.done && (step.kind == STEP_RD_CHK) &&
                        !dev.rdata[SSR_TX_BUFFER_EMPTY]);

  // Sticky done and refused flags; a set in the same cycle as a software clear wins. The break flag follows the last extended status read.
  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      done_q <= 1'b0;
      refused_q <= 1'b0;
      break_q <= 1'b0;
    end else begin
      done_q <= set_done || (done_q && !(apb_wr && (I_PADDR == APB_STATUS) &&
                                         I_PWDATA[ST_DONE]));
      refused_q <= set_refused || (refused_q && !(apb_wr && (I_PADDR == APB_STATUS) &&
                                                  I_PWDATA[ST_REFUSED]));
      if ((state_q == S_WAIT) && dev.done && !we_q && (addr_q == DEV_EXT_STATUS_CTRL)) begin
        break_q <= dev.rdata[EXTENDED_STATUS_CONTROL_LBD];
      end
    end
  end

  lcu_dev_port u_port (
    .i_clock(I_CLOCK),
    .i_rst(I_RST),
    .bus(dev.port),
    .o_strobe(O_DEV_STROBE),
    .o_write(O_DEV_WRITE),
    .o_addr(O_DEV_ADDR),
    .o_wdata(O_DEV_WDATA),
    .i_ack(I_DEV_ACK),
    .i_rdata(I_DEV_RDATA)
  );

  // Helper history of the previous device write and the control transmit enable.
  logic [2:0] last_addr_q;
  logic [7:0] last_data_q;
  logic scr_txe_q;
  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      last_addr_q <= 3'h7;
      last_data_q <= 8'h00;
      scr_txe_q <= 1'b0;
    end else if (req_q && we_q) begin
      last_addr_q <= addr_q;
      last_data_q <= wdata_q;
      if (addr_q == DEV_SERIAL_CONTROL) begin
        scr_txe_q <= wdata_q[SCR_TXE];
      end
    end
  end

  sequence clear_wr_s;
    req_q && we_q && addr_q == DEV_SERIAL_MODE && wdata_q[SMR_SOFT_CLEAR];
  endsequence
  sequence config_end_s;
    state_q == S_ISSUE && cmd_q == CMD_CONFIG && step.kind == STEP_END;
  endsequence

  apb_ready_a: assert property (@(posedge I_CLOCK) disable iff (I_RST)
    I_PSEL && !I_PENABLE |=> O_PREADY ##1 !O_PREADY)
    else $error("APB answer not one cycle after setup.");
  break_mode_a: assert property (@(posedge I_CLOCK) disable iff (I_RST)
    req_q && addr_q == DEV_EXT_COMM_CTRL |-> cfg_q[CFG_MODE_LO+:2] == MODE_LIN)
    else $error("Break requested outside LIN mode.");
  clear_txe_a: assert property (@(posedge I_CLOCK) disable iff (I_RST)
    clear_wr_s |-> !scr_txe_q)
    else $error("Soft clear issued with transmit enabled.");
  clear_separate_a: assert property (@(posedge I_CLOCK) disable iff (I_RST)
    (clear_wr_s and (cmd_q == CMD_CONFIG)) |-> last_addr_q == DEV_SERIAL_MODE &&
      !last_data_q[SMR_SOFT_CLEAR] && last_data_q[SMR_MODE_LO+:2] == wdata_q[SMR_MODE_LO+:2])
    else $error("Soft clear not separate from mode write.");
  lin_format_a: assert property (@(posedge I_CLOCK) disable iff (I_RST)
    req_q && addr_q == DEV_SERIAL_CONTROL && cfg_q[CFG_MODE_LO+:2] == MODE_LIN |->
      wdata_q[SCR_CL] && !wdata_q[SCR_PEN] && !wdata_q[SCR_SBL])
    else $error("LIN frame format not forced.");
  tie_after_data_a: assert property (@(posedge I_CLOCK) disable iff (I_RST)
    req_q && addr_q == DEV_SERIAL_STATUS && wdata_q[SSR_TIE] |-> last_addr_q == DEV_TX_DATA)
    else $error("Transmit interrupt enabled before data load.");
  pin_order_a: assert property (@(posedge I_CLOCK) disable iff (I_RST)
    req_q && cmd_q == CMD_PIN_OUT && addr_q == DEV_SERIAL_MODE |->
      wdata_q[SMR_SOE] && last_addr_q == DEV_EXT_STATUS_CTRL && last_data_q[EXTENDED_STATUS_CONTROL_PIN_WRITE_ENABLE])
    else $error("Output enabled before direct level written.");
  pin_busy_a: assert property (@(posedge I_CLOCK) disable iff (I_RST)
    state_q == S_WAIT && dev.done && step.kind == STEP_RD_CHK && !dev.rdata[SSR_TX_BUFFER_EMPTY] |=>
      refused_q && state_q == S_IDLE ##1 !req_q[*3])
    else $error("Direct access proceeded while transmitting.");
  config_enable_a: assert property (@(posedge I_CLOCK) disable iff (I_RST)
    config_end_s |-> scr_txe_q ##1 done_q)
    else $error("Configuration finished without enabling transfer.");
endmodule

/* File: inc/lcu_dev_if.sv */
`timescale 1ns/1ps
interface lcu_dev_if;
  logic req;
  logic we;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic done;
  logic [7:0] rdata;
  modport ctl(output req, output we, output addr, output wdata, input done, input rdata);
  modport port(input req, input we, input addr, input wdata, output done, output rdata);
endinterface

/* File: inc/lcu_pkg.sv */
package lcu_pkg;
  // Device register indices on the device's own register port.
  localparam logic [2:0] DEV_SERIAL_MODE = 3'h0;
  localparam logic [2:0] DEV_SERIAL_CONTROL = 3'h1;
  localparam logic [2:0] DEV_SERIAL_STATUS = 3'h2;
  localparam logic [2:0] DEV_EXT_STATUS_CTRL = 3'h3;
  localparam logic [2:0] DEV_EXT_COMM_CTRL = 3'h4;
  localparam logic [2:0] DEV_TX_DATA = 3'h5;
  // Serial mode register fields.
  localparam int SMR_MODE_LO = 6;
  localparam int SMR_SOFT_CLEAR = 2;
  localparam int SMR_SOE = 0;
  // Serial control register fields.
  localparam int SCR_PEN = 7;
  localparam int SCR_PAR = 6;
  localparam int SCR_SBL = 5;
  localparam int SCR_CL = 4;
  localparam int SCR_AD = 3;
  localparam int SCR_RXE = 1;
  localparam int SCR_TXE = 0;
  // Serial status register fields.
  localparam int SSR_TX_BUFFER_EMPTY = 3;
  localparam int SSR_BDS = 2;
  localparam int SSR_TIE = 0;
  // Extended status control register fields.
  localparam int EXTENDED_STATUS_CONTROL_BREAK_IRQ_ENABLE = 7;
  localparam int EXTENDED_STATUS_CONTROL_LBD = 6;
  localparam int EXTENDED_STATUS_CONTROL_LBL_LO = 4;
  localparam int EXTENDED_STATUS_CONTROL_PIN_WRITE_ENABLE = 3;
  localparam int EXTENDED_STATUS_CONTROL_PIN_DIRECT_BIT = 2;
  // Extended communication control register fields.
  localparam int EXTENDED_COMM_CONTROL_LBR = 6;
  // Operating modes in the two-bit mode field.
  localparam logic [1:0] MODE_ASYNC = 2'h0;
  localparam logic [1:0] MODE_MULTI = 2'h1;
  localparam logic [1:0] MODE_SYNC = 2'h2;
  localparam logic [1:0] MODE_LIN = 2'h3;
  // APB register offsets of this controller.
  localparam logic [11:0] APB_CMD = 12'h000;
  localparam logic [11:0] APB_CFG = 12'h004;
  localparam logic [11:0] APB_TXDATA = 12'h008;
  localparam logic [11:0] APB_STATUS = 12'h00C;
  // Configuration register fields.
  localparam int CFG_MODE_LO = 0;
  localparam int CFG_CL = 2;
  localparam int CFG_SBL = 3;
  localparam int CFG_PEN = 4;
  localparam int CFG_PAR = 5;
  localparam int CFG_BDS = 6;
  localparam int CFG_AD = 7;
  localparam int CFG_LBL_LO = 8;
  localparam int CFG_BREAK_IRQ_ENABLE = 10;
  localparam int CFG_PIN_LEVEL = 11;
  localparam int CFG_SOE = 12;
  localparam int CFG_W = 13;
  // Status register fields.
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_REFUSED = 2;
  localparam int ST_BREAK = 3;
  localparam int ST_RDATA_LO = 8;
  typedef enum logic [3:0] {
    CMD_NONE, CMD_CONFIG, CMD_SEND, CMD_BREAK, CMD_PIN_OUT,
    CMD_READ_EXT, CMD_BRK_CLR, CMD_RECOVER, CMD_STOP
  } lcu_cmd_t;
  typedef enum logic [1:0] {STEP_END, STEP_WR, STEP_RD, STEP_RD_CHK} lcu_kind_t;
  typedef struct packed {
    lcu_kind_t kind;
    logic [2:0] addr;
    logic [7:0] data;
  } lcu_step_t;
endpackage

/* File: verification/lcu_dev_model.sv */
`timescale 1ns/1ps
module lcu_dev_model
  import lcu_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_strobe,
  input wire logic i_write,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_sin,
  input wire logic i_brk,
  input wire logic [3:0] i_lag,
  output logic o_ack,
  output logic [7:0] o_rdata
);
  logic [7:0] r [0:5];
  logic [3:0] lag_q;
  logic [5:0] shift_q;
  // Four-phase device side; released data is inverted so a stale byte is never mistaken.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      for (int k = 0; k < 6; k++) begin
        r[k] <= 8'h00;
      end
      r[2] <= 8'h08;
      o_ack <= 1'b0;
      o_rdata <= 8'h00;
      lag_q <= 4'h0;
      shift_q <= 6'h00;
    end else begin
      lag_q <= (i_strobe && !o_ack) ? lag_q + 4'h1 : 4'h0;
      if (shift_q != 6'h00) begin
        shift_q <= shift_q - 6'h01;
      end
      if (shift_q == 6'h01) begin
        r[2][SSR_TX_BUFFER_EMPTY] <= 1'b1;
      end
      if (i_brk) begin
        r[3][EXTENDED_STATUS_CONTROL_LBD] <= 1'b1;
      end
      if (i_strobe && !o_ack && lag_q >= i_lag) begin
        o_ack <= 1'b1;
        o_rdata <= (i_addr == 3'h3) ? {r[3][7:3], i_sin, r[3][1:0]} : r[i_addr];
        if (i_write) begin
          r[i_addr] <= i_wdata;
        end
        if (i_write && i_addr == 3'h2) begin
          r[2][SSR_TX_BUFFER_EMPTY] <= r[2][SSR_TX_BUFFER_EMPTY];
        end
        if (i_write && i_addr == 3'h3) begin
          r[3][EXTENDED_STATUS_CONTROL_LBD] <= r[3][EXTENDED_STATUS_CONTROL_LBD] & i_wdata[EXTENDED_STATUS_CONTROL_LBD];
        end
        if (i_write && i_addr == 3'h5) begin
          r[2][SSR_TX_BUFFER_EMPTY] <= 1'b0;
          shift_q <= 6'h3F;
        end
      end else if (!i_strobe && o_ack) begin
        o_ack <= 1'b0;
        o_rdata <= ~o_rdata;
      end
    end
  end
endmodule

/* File: verification/lcu_host_tb.sv */
`timescale 1ns/1ps
module lcu_host_tb;
  import lcu_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic serial_in_pin = 1'b1;
  logic brk = 1'b0;
  logic [3:0] lag = 4'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, strobe, dwrite, ack, e;
  logic [2:0] daddr;
  logic [7:0] dwdata, drdata;
  int err_total = 0;
  int checks = 0;
  // Free-running 100 MHz clock.
  always #5 clk = ~clk;
  lcu_host i_lcu_host (.I_CLOCK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .O_DEV_STROBE(strobe), .O_DEV_WRITE(dwrite),
    .O_DEV_ADDR(daddr), .O_DEV_WDATA(dwdata), .I_DEV_ACK(ack), .I_DEV_RDATA(drdata));
  lcu_dev_model i_lcu_dev_model (.i_clock(clk), .i_rst(rst), .i_strobe(strobe),
    .i_write(dwrite), .i_addr(daddr), .i_wdata(dwdata), .i_sin(serial_in_pin), .i_brk(brk),
    .i_lag(lag), .o_ack(ack), .o_rdata(drdata));
  task automatic print_verdict();
    $display("Counts: %0d checks, %0d mismatches", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [7:0] dr(input int k);
    return i_lcu_dev_model.r[k];
  endfunction
  // One APB transfer; the request is held until pready is seen high.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (n >= 40) begin
      err_total++;
      print_verdict();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  // Issues a command and polls status until the controller is idle again.
  task automatic run(input lcu_cmd_t c);
    int n;
    apb(1'b1, APB_CMD, {28'h0, c});
    n = 0;
    do begin
      apb(1'b0, APB_STATUS, 32'h0);
      n++;
    end while (q[ST_BUSY] !== 1'b0 && n < 100);
    if (n >= 100) begin
      err_total++;
      print_verdict();
    end
  endtask
  // Main sequence.
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, APB_STATUS, 32'h0);
    chk("status", q, 32'h0);
    chk("ctrl", dr(1), 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped", {q[30:0], e}, 32'h1);
    $display("Test reset done");
    for (int m = 0; m < 4; m++) begin
      lag <= 4'(m * 3);
      apb(1'b1, APB_CFG, 32'h250 | m);
      run(CMD_CONFIG);
      chk("mode", dr(0) >> 6, m);
      chk("len", dr(1) >> SCR_CL & 1, m == 3);
      chk("par", dr(1) >> SCR_PEN & 1, m % 2 == 0);
      chk("msb", dr(2) >> SSR_BDS & 1, m != 3);
      chk("txe", dr(1) & 3, 3);
      apb(1'b1, APB_STATUS, 32'h4);
      run(CMD_BREAK);
      chk("brk refused", q[ST_REFUSED], m != 3);
    end
    chk("brk req", dr(4), 8'h40);
    chk("brk len", dr(3) >> EXTENDED_STATUS_CONTROL_LBL_LO & 3, 2);
    $display("Test modes done");
    lag <= 4'h0;
    apb(1'b1, APB_CFG, 32'h85);
    apb(1'b0, APB_CFG, 32'h0);
    chk("cfg", q, 32'h85);
    run(CMD_CONFIG);
    apb(1'b1, APB_TXDATA, 32'hA5);
    run(CMD_SEND);
    chk("addr frame", dr(1) >> SCR_AD & 1, 1);
    chk("txdata", dr(5), 8'hA5);
    chk("tie", dr(2) & 1, 1);
    run(CMD_PIN_OUT);
    chk("pin refused", q[ST_REFUSED], 1);
    repeat (70) @(posedge clk);
    apb(1'b1, APB_STATUS, 32'h6);
    // The mode field stays at 1, because pin access rewrites the mode register while running.
    apb(1'b1, APB_CFG, 32'h1885);
    run(CMD_PIN_OUT);
    chk("pin ok", q[ST_REFUSED], 0);
    chk("pin_write_enable", dr(3) >> EXTENDED_STATUS_CONTROL_PIN_WRITE_ENABLE & 1, 1);
    chk("pin_direct_bit", dr(3) >> EXTENDED_STATUS_CONTROL_PIN_DIRECT_BIT & 1, 1);
    chk("soe", dr(0) & 1, 1);
    $display("Test send and pin done");
    lag <= 4'h6;
    serial_in_pin <= 1'b0;
    brk <= 1'b1;
    @(posedge clk);
    brk <= 1'b0;
    apb(1'b1, APB_CMD, 32'h5);
    apb(1'b1, APB_CMD, 32'h8);
    run(CMD_NONE);
    chk("busy refused", q[ST_REFUSED], 1);
    chk("still on", dr(1) & 1, 1);
    chk("brk flag", q[ST_BREAK], 1);
    chk("sin low", q[ST_RDATA_LO + EXTENDED_STATUS_CONTROL_PIN_DIRECT_BIT], 0);
    serial_in_pin <= 1'b1;
    run(CMD_READ_EXT);
    chk("sin high", q[ST_RDATA_LO + EXTENDED_STATUS_CONTROL_PIN_DIRECT_BIT], 1);
    run(CMD_BRK_CLR);
    chk("brk clr", dr(3) >> EXTENDED_STATUS_CONTROL_LBD & 1, 0);
    run(CMD_RECOVER);
    chk("recover", dr(1) & 3, 3);
    run(CMD_STOP);
    chk("stop", dr(1) & 3, 0);
    $display("Test break done");
    print_verdict();
  end
endmodule
